// [common/cbctl_pkg.sv]
/*
 * Constants, types and decode helpers for the card bridge control registers.
 * Assumes a configuration port that presents one dword access per request.
 */
// Overview of operation
// [R1] posting bit 10 posts burst writes, per socket
// [R2] only burst writes are ever posted
// [R3] bit 9: window 1 prefetchable, reset one
// [R4] bit 8: window 0 prefetchable, reset one
// [R5] bit 7 routes card interrupts to legacy
// [R6] bit 6 drives card reset low
// [R7] primary reset input also drives card reset
// [R8] bit 5: master abort gives target abort
// [R9] bit 3 forwards VGA ranges to card
// [R10] bit 2 blocks upper 768 bytes per 1K
// [R11] bit 1 forwards card system error
// [R12] bit 0 enables card parity error drive
// [R13] bits 5,1,0 shared, written via function 0
// [R14] reserved control bits read zero
// [R15] control at 3Eh, resets to 0340h
// [R16] ident registers writable only when enabled
// [R17] idents at 40h and 42h, reset zero
// [R18] prefetch bits steer their memory windows
// [R19] function 1 reads function 0 globals
package cbctl_pkg;

    localparam logic [7:0]  OFF_BRIDGE_CTRL = 8'h3e;
    localparam logic [7:0]  OFF_SUBSYS_VID  = 8'h40;
    localparam logic [7:0]  OFF_SUBSYS_ID   = 8'h42;
    localparam logic [5:0]  DW_CTRL         = OFF_BRIDGE_CTRL[7:2];
    localparam logic [5:0]  DW_IDENT        = OFF_SUBSYS_VID[7:2];

    localparam int BIT_POST   = 10;
    localparam int BIT_PF1    = 9;
    localparam int BIT_PF0    = 8;
    localparam int BIT_IRQ    = 7;
    localparam int BIT_CRST   = 6;
    localparam int BIT_MABT   = 5;
    localparam int BIT_VGA    = 3;
    localparam int BIT_ISA    = 2;
    localparam int BIT_CSERR  = 1;
    localparam int BIT_CPERR  = 0;

    localparam logic [15:0] CTRL_RESET      = 16'h0340;
    localparam logic [15:0] CTRL_LOCAL_MASK = 16'h07cc;
    localparam logic [15:0] CTRL_GLOB_MASK  = 16'h0023;
    localparam logic [15:0] IDENT_RESET     = 16'h0000;

    localparam logic [31:0] VGA_MEM_FIRST   = 32'h000a_0000;
    localparam logic [31:0] VGA_MEM_LAST    = 32'h000b_ffff;
    localparam logic [9:0]  VGA_IO0_FIRST   = 10'h3b0;
    localparam logic [9:0]  VGA_IO0_LAST    = 10'h3bb;
    localparam logic [9:0]  VGA_IO1_FIRST   = 10'h3c0;
    localparam logic [9:0]  VGA_IO1_LAST    = 10'h3df;
    localparam logic [15:0] ISA_IO_PAGE     = 16'h0000;

    typedef struct packed {
        logic        req;
        logic        we;
        logic        func;
        logic [5:0]  dword;
        logic [3:0]  be;
        logic [31:0] wdata;
    } cbctl_cfg_s;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] ssvid;
        logic [15:0] ssid;
    } cbctl_func_s;

    typedef struct packed {
        logic write_post_enable;
        logic mem_window1_prefetchable;
        logic mem_window0_prefetchable;
        logic legacy_irq_route_select;
        logic vga_forward_enable;
        logic isa_range_filter_enable;
    } cbctl_sock_s;

    typedef struct packed {
        logic master_abort_report_mode;
        logic card_syserr_forward_enable;
        logic card_parity_response_enable;
    } cbctl_glob_s;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ack;
        logic [15:0] glob;
        logic [1:0]  card_reset_n;
        logic [1:0]  perr_n;
        logic        serr_n;
        logic [1:0]  tabort;
        logic [1:0]  vga;
        logic [1:0]  isab;
        logic [1:0]  post;
    } cbctl_top_s;

    // vga io decode uses 10 bits, so aliases above 1K hit as well
    function automatic logic vga_hit(input logic [31:0] a,
                                     input logic        is_io);
        logic [9:0] lo;
        lo = a[9:0];
        if (is_io)
            vga_hit = (lo >= VGA_IO0_FIRST && lo <= VGA_IO0_LAST) ||
                      (lo >= VGA_IO1_FIRST && lo <= VGA_IO1_LAST);
        else
            vga_hit = (a >= VGA_MEM_FIRST && a <= VGA_MEM_LAST);
    endfunction : vga_hit

    function automatic logic isa_block(input logic [31:0] a,
                                       input logic        is_io);
        isa_block = is_io && (a[31:16] == ISA_IO_PAGE) &&
                    (a[9:8] != 2'b00);
    endfunction : isa_block

endpackage : cbctl_pkg

// [design/cbctl_bridge_ctrl.sv]
/*
 * Bridge control and subsystem ident registers for a two-socket card
 * bridge, with the socket-side effects of each control bit.
 * Assumes configuration requests and socket events are synchronous to
 * clk_i; the configuration port takes one dword access per request.
 */
`timescale 1ns/1ps
module cbctl_bridge_ctrl (
    input  wire logic                     clk_i,            // 10 MHz clock
    input  wire logic                     rst_i,            // async, high
    input  cbctl_pkg::cbctl_cfg_s         cfg_i,            // config request
    output logic [31:0]                   cfg_rdata_o,      // read data
    output logic                          cfg_ack_o,        // ack pulse
    input  wire logic [1:0]               ident_write_enable_i, // per func
    input  wire logic                     primary_reset_in_i, // passed reset
    input  wire logic                     serr_report_enable_i, // SERR en
    input  wire logic [1:0]               burst_write_i,    // burst write
    input  wire logic [1:0]               card_syserr_n_i,  // CSERR#, low
    input  wire logic [1:0]               card_parity_err_i, // parity err
    input  wire logic [1:0]               card_master_abort_i, // abort seen
    input  wire logic [31:0]              fwd_addr_i,       // decode addr
    input  wire logic                     fwd_is_io_i,      // io cycle
    output cbctl_pkg::cbctl_sock_s [1:0]  sock_ctl_o,       // socket ctrl
    output cbctl_pkg::cbctl_glob_s        glob_ctl_o,       // shared ctrl
    output logic [1:0]                    post_write_o,     // post this
    output logic [1:0]                    card_reset_n_o,   // CRST#, low
    output logic [1:0]                    card_perr_n_o,    // CPERR#, low
    output logic                          pci_serr_n_o,     // SERR#, low
    output logic [1:0]                    target_abort_o,   // target abort
    output logic [1:0]                    vga_claim_o,      // vga forward
    output logic [1:0]                    isa_block_o       // isa blocked
);

    ////////////////////////////////////////////////////////////////////////
    // per-function copies

    cbctl_pkg::cbctl_func_s [1:0] fr;
    cbctl_pkg::cbctl_top_s        q, d;

    for (genvar g = 0; g < 2; g++) begin : g_func
        cbctl_func_regs u_regs (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .wr_i     (cfg_i.req && cfg_i.we && (cfg_i.func == 1'(g))),
            .dword_i  (cfg_i.dword),
            .be_i     (cfg_i.be),
            .wdata_i  (cfg_i.wdata),
            .id_wen_i (ident_write_enable_i[g]),
            .regs_o   (fr[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [15:0] ctrl_rd;
        logic        serr;
        ctrl_rd = 16'h0000;
        serr    = 1'b0;
        d       = q;
        d.ack   = cfg_i.req;
        d.rdata = 32'h0000_0000;

        // shared bits live only here; function 1 reads them too
        ctrl_rd = fr[cfg_i.func].ctrl | q.glob; // R19
        if (cfg_i.req && !cfg_i.we) begin
            case (cfg_i.dword)
                cbctl_pkg::DW_CTRL:
                    d.rdata = {ctrl_rd, 16'h0000}; // R15
                cbctl_pkg::DW_IDENT:
                    d.rdata = {fr[cfg_i.func].ssid,
                               fr[cfg_i.func].ssvid}; // R17
                default:
                    d.rdata = 32'h0000_0000;
            endcase
        end

        // writes through function 1 never reach the shared bits
        if (cfg_i.req && cfg_i.we && !cfg_i.func &&
            cfg_i.dword == cbctl_pkg::DW_CTRL && cfg_i.be[2]) begin // R13
            d.glob[7:0] = cfg_i.wdata[23:16] &
                          cbctl_pkg::CTRL_GLOB_MASK[7:0]; // R13
        end

        for (int s = 0; s < 2; s++) begin
            d.card_reset_n[s] = !(fr[s].ctrl[cbctl_pkg::BIT_CRST] // R6
                                  || primary_reset_in_i); // R7
            d.perr_n[s] = !(q.glob[cbctl_pkg::BIT_CPERR] &&
                            card_parity_err_i[s]); // R12
            d.tabort[s] = q.glob[cbctl_pkg::BIT_MABT] &&
                          card_master_abort_i[s]; // R8
            d.post[s]   = fr[s].ctrl[cbctl_pkg::BIT_POST] && // R1
                          burst_write_i[s]; // R2
            d.vga[s]    = fr[s].ctrl[cbctl_pkg::BIT_VGA] &&
                          cbctl_pkg::vga_hit(fwd_addr_i, fwd_is_io_i); // R9
            d.isab[s]   = fr[s].ctrl[cbctl_pkg::BIT_ISA] &&
                          cbctl_pkg::isa_block(fwd_addr_i,
                                               fwd_is_io_i); // R10
            if (q.glob[cbctl_pkg::BIT_CSERR] && !card_syserr_n_i[s]) begin
                serr = 1'b1; // R11
            end
            // an unreported abort stays silent on SERR# as well
            if (q.glob[cbctl_pkg::BIT_MABT] && serr_report_enable_i &&
                card_master_abort_i[s]) begin
                serr = 1'b1; // R8
            end
        end
        d.serr_n = !serr;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q.rdata        <= 32'h0000_0000;
            q.ack          <= 1'b0;
            q.glob         <= cbctl_pkg::CTRL_RESET &
                              cbctl_pkg::CTRL_GLOB_MASK; // R15
            q.card_reset_n <= 2'b00; // R6
            q.perr_n       <= 2'b11;
            q.serr_n       <= 1'b1;
            q.tabort       <= 2'b00;
            q.vga          <= 2'b00;
            q.isab         <= 2'b00;
            q.post         <= 2'b00;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb begin
        for (int s = 0; s < 2; s++) begin
            sock_ctl_o[s].write_post_enable =
                fr[s].ctrl[cbctl_pkg::BIT_POST]; // R1
            // window hit logic downstream picks prefetch per window
            sock_ctl_o[s].mem_window1_prefetchable =
                fr[s].ctrl[cbctl_pkg::BIT_PF1]; // R3 R18
            sock_ctl_o[s].mem_window0_prefetchable =
                fr[s].ctrl[cbctl_pkg::BIT_PF0]; // R4 R18
            sock_ctl_o[s].legacy_irq_route_select =
                fr[s].ctrl[cbctl_pkg::BIT_IRQ]; // R5
            sock_ctl_o[s].vga_forward_enable =
                fr[s].ctrl[cbctl_pkg::BIT_VGA]; // R9
            sock_ctl_o[s].isa_range_filter_enable =
                fr[s].ctrl[cbctl_pkg::BIT_ISA]; // R10
        end
    end

    assign glob_ctl_o.master_abort_report_mode =
        q.glob[cbctl_pkg::BIT_MABT]; // R13
    assign glob_ctl_o.card_syserr_forward_enable =
        q.glob[cbctl_pkg::BIT_CSERR]; // R13
    assign glob_ctl_o.card_parity_response_enable =
        q.glob[cbctl_pkg::BIT_CPERR]; // R13

    assign cfg_rdata_o    = q.rdata;
    assign cfg_ack_o      = q.ack;
    assign post_write_o   = q.post;
    assign card_reset_n_o = q.card_reset_n;
    assign card_perr_n_o  = q.perr_n;
    assign pci_serr_n_o   = q.serr_n;
    assign target_abort_o = q.tabort;
    assign vga_claim_o    = q.vga;
    assign isa_block_o    = q.isab;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_card_reset_on: // R6
    assert property ((fr[0].ctrl[cbctl_pkg::BIT_CRST] || primary_reset_in_i)
                     |=> !card_reset_n_o[0])
        else $error("card reset not asserted");

    a_card_reset_off: // R7
    assert property ((!fr[1].ctrl[cbctl_pkg::BIT_CRST] && !primary_reset_in_i)
                     |=> card_reset_n_o[1])
        else $error("card reset not released");

    a_serr_forward: // R11
    assert property ((!card_syserr_n_i[0]
                      && glob_ctl_o.card_syserr_forward_enable)
                     |=> !pci_serr_n_o)
        else $error("card system error not forwarded");

    a_serr_quiet: // R11
    assert property ((card_syserr_n_i == 2'b11 && card_master_abort_i == 2'b00)
                     |=> pci_serr_n_o)
        else $error("SERR# driven without cause");

    a_abort_mode: // R8
    assert property (card_master_abort_i[1]
                     |=> target_abort_o[1]
                         == $past(q.glob[cbctl_pkg::BIT_MABT]))
        else $error("target abort disagrees with abort mode");

    a_parity_gate: // R12
    assert property (card_parity_err_i[0]
                     |=> card_perr_n_o[0]
                         != $past(q.glob[cbctl_pkg::BIT_CPERR]))
        else $error("parity error drive disagrees with enable");

    a_glob_func1: // R13
    assert property ((cfg_i.req && cfg_i.we && cfg_i.func)
                     |=> $stable(q.glob))
        else $error("function 1 write changed shared bits");

    a_rsvd_read: // R14
    assert property ((cfg_i.req && !cfg_i.we
                      && cfg_i.dword == cbctl_pkg::DW_CTRL)
                     |=> cfg_ack_o
                         && (cfg_rdata_o[31:16]
                             & ~(cbctl_pkg::CTRL_LOCAL_MASK
                                 | cbctl_pkg::CTRL_GLOB_MASK)) == 16'h0000)
        else $error("reserved control bits read nonzero");

    a_isa_pass: // R10
    assert property ((fwd_is_io_i && fwd_addr_i[9:8] == 2'b00)
                     |=> !isa_block_o[0])
        else $error("lower 256 bytes of a 1K block were blocked");

    a_post_burst: // R2
    assert property (!burst_write_i[0] |=> !post_write_o[0])
        else $error("non-burst write posted");

    a_ack_pulse: // R15
    assert property (cfg_i.req |=> cfg_ack_o)
        else $error("config request not acknowledged");

    a_ack_quiet: // R15
    assert property (!cfg_i.req |=> !cfg_ack_o)
        else $error("acknowledge without a request");

    a_write_rdata: // R15
    assert property ((cfg_i.req && cfg_i.we)
                     |=> cfg_rdata_o == 32'h0000_0000)
        else $error("read data shown on a write");

    a_func1_glob: // R19
    assert property ((cfg_i.req && !cfg_i.we && cfg_i.func
                      && cfg_i.dword == cbctl_pkg::DW_CTRL)
                     |=> (cfg_rdata_o[31:16] & cbctl_pkg::CTRL_GLOB_MASK)
                         == $past(q.glob))
        else $error("function 1 read lost the shared bits");

    a_ident_read: // R17
    assert property ((cfg_i.req && !cfg_i.we && !cfg_i.func
                      && cfg_i.dword == cbctl_pkg::DW_IDENT)
                     |=> cfg_rdata_o == {$past(fr[0].ssid),
                                         $past(fr[0].ssvid)})
        else $error("ident read disagrees with the stored words");

    a_glob_write: // R13
    assert property ((cfg_i.req && cfg_i.we && !cfg_i.func && cfg_i.be[2]
                      && cfg_i.dword == cbctl_pkg::DW_CTRL
                      && cfg_i.wdata[16 + cbctl_pkg::BIT_CSERR])
                     |=> glob_ctl_o.card_syserr_forward_enable)
        else $error("function 0 write missed a shared bit");

    a_glob_rsvd: // R14
    assert property ((q.glob & ~cbctl_pkg::CTRL_GLOB_MASK) == 16'h0000)
        else $error("shared copy holds a bit outside its mask");

    a_reset_passed: // R7
    assert property (primary_reset_in_i |=> card_reset_n_o == 2'b00)
        else $error("primary reset not passed to both sockets");

    a_reset_sock1: // R6
    assert property (fr[1].ctrl[cbctl_pkg::BIT_CRST] |=> !card_reset_n_o[1])
        else $error("socket 1 card reset not asserted");

    a_post_on: // R1
    assert property ((fr[0].ctrl[cbctl_pkg::BIT_POST] && burst_write_i[0])
                     |=> post_write_o[0])
        else $error("enabled burst write not posted");

    a_post_off: // R1
    assert property (!fr[1].ctrl[cbctl_pkg::BIT_POST] |=> !post_write_o[1])
        else $error("write posted while posting disabled");

    a_vga_mem: // R9
    assert property ((fr[0].ctrl[cbctl_pkg::BIT_VGA] && !fwd_is_io_i
                      && fwd_addr_i == cbctl_pkg::VGA_MEM_FIRST)
                     |=> vga_claim_o[0])
        else $error("vga memory access not forwarded");

    a_vga_off: // R9
    assert property (!fr[1].ctrl[cbctl_pkg::BIT_VGA] |=> !vga_claim_o[1])
        else $error("vga access forwarded while disabled");

    a_isa_block: // R10
    assert property ((fr[0].ctrl[cbctl_pkg::BIT_ISA] && fwd_is_io_i
                      && fwd_addr_i[31:16] == cbctl_pkg::ISA_IO_PAGE
                      && fwd_addr_i[9:8] != 2'b00)
                     |=> isa_block_o[0])
        else $error("upper part of a 1K block was forwarded");

    a_isa_off: // R10
    assert property (!fr[1].ctrl[cbctl_pkg::BIT_ISA] |=> !isa_block_o[1])
        else $error("isa filter active while disabled");

    a_abort_off: // R8
    assert property (!q.glob[cbctl_pkg::BIT_MABT] |=> target_abort_o == 2'b00)
        else $error("target abort while aborts unreported");

    a_parity_off: // R12
    assert property (!q.glob[cbctl_pkg::BIT_CPERR] |=> card_perr_n_o == 2'b11)
        else $error("parity error driven while disabled");

    a_serr_masked: // R11
    assert property ((!q.glob[cbctl_pkg::BIT_CSERR] && !serr_report_enable_i)
                     |=> pci_serr_n_o)
        else $error("SERR# driven while all sources masked");

endmodule : cbctl_bridge_ctrl

// [design/cbctl_func_regs.sv]
/*
 * Per-function register copy: local control bits and the two ident words.
 * Assumes the parent decodes the function number and drives wr_i.
 */
`timescale 1ns/1ps
module cbctl_func_regs (
    input  wire logic                  clk_i,    // 10 MHz clock
    input  wire logic                  rst_i,    // async reset, high
    input  wire logic                  wr_i,     // write to this function
    input  wire logic [5:0]            dword_i,  // dword index
    input  wire logic [3:0]            be_i,     // byte enables, high
    input  wire logic [31:0]           wdata_i,  // write data
    input  wire logic                  id_wen_i, // ident write enable
    output cbctl_pkg::cbctl_func_s     regs_o    // registered copy
);

    cbctl_pkg::cbctl_func_s q, d;

    always_comb begin
        d = q;
        if (wr_i && dword_i == cbctl_pkg::DW_CTRL) begin
            // masks keep reserved and global bits at zero here
            if (be_i[2]) begin
                d.ctrl[7:0] = wdata_i[23:16] &
                              cbctl_pkg::CTRL_LOCAL_MASK[7:0]; // R14
            end
            if (be_i[3]) begin
                d.ctrl[15:8] = wdata_i[31:24] &
                               cbctl_pkg::CTRL_LOCAL_MASK[15:8]; // R14
            end
        end
        if (wr_i && id_wen_i && dword_i == cbctl_pkg::DW_IDENT) begin // R16
            if (be_i[0]) d.ssvid[7:0]  = wdata_i[7:0];
            if (be_i[1]) d.ssvid[15:8] = wdata_i[15:8];
            if (be_i[2]) d.ssid[7:0]   = wdata_i[23:16];
            if (be_i[3]) d.ssid[15:8]  = wdata_i[31:24];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            q.ctrl  <= cbctl_pkg::CTRL_RESET; // R15
            q.ssvid <= cbctl_pkg::IDENT_RESET; // R17
            q.ssid  <= cbctl_pkg::IDENT_RESET; // R17
        end else begin
            q <= d;
        end
    end

    assign regs_o = q;

    a_ident_ro: // R16
    assert property (@(posedge clk_i) disable iff (rst_i)
        !id_wen_i |=> $stable({q.ssvid, q.ssid}))
        else $error("ident changed while write disabled");

    a_ctrl_rsvd: // R14
    assert property (@(posedge clk_i) disable iff (rst_i)
        wr_i |=> (q.ctrl & ~cbctl_pkg::CTRL_LOCAL_MASK) == 16'h0000)
        else $error("local control holds a bit outside its mask");

endmodule : cbctl_func_regs

// [sim/cbctl_bridge_ctrl_tb.sv]
/*
 * Self-checking bench for the bridge control registers.
 * Assumes the design answers each config request one cycle later.
 */
`timescale 1ns/1ps
module cbctl_bridge_ctrl_tb;
    logic                         clk_i = 1'b0;
    logic                         rst_i = 1'b1;
    cbctl_pkg::cbctl_cfg_s        cfg_i = '0;
    logic [1:0]                   id_wen = 2'b00;
    logic                         primary_reset_in = 1'b0;
    logic                         serr_en = 1'b0;
    logic [0:0]                   sock = 1'b0;
    logic [2:0]                   ev = 3'd0;
    logic [31:0]                  addr = 32'h0000_0000;
    logic                         is_io = 1'b0;
    logic [1:0]                   burst, syserr_n, perr, mabort;
    logic [31:0]                  rdata;
    logic                         ack, serr_n;
    cbctl_pkg::cbctl_sock_s [1:0] sctl;
    cbctl_pkg::cbctl_glob_s       gctl;
    logic [1:0]                   post, crst_n, perr_n, tab, vga, isab;
    int                           bad_count = 0;
    int                           compares = 0;

    always #50 clk_i = ~clk_i;

    cbctl_card_model u_cbctl_card_model (
        .sock_i(sock), .ev_i(ev), .burst_o(burst),
        .syserr_n_o(syserr_n), .perr_o(perr), .mabort_o(mabort));

    cbctl_bridge_ctrl u_cbctl_bridge_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg_i),
        .cfg_rdata_o(rdata), .cfg_ack_o(ack),
        .ident_write_enable_i(id_wen), .primary_reset_in_i(primary_reset_in),
        .serr_report_enable_i(serr_en), .burst_write_i(burst),
        .card_syserr_n_i(syserr_n), .card_parity_err_i(perr),
        .card_master_abort_i(mabort), .fwd_addr_i(addr),
        .fwd_is_io_i(is_io), .sock_ctl_o(sctl), .glob_ctl_o(gctl),
        .post_write_o(post), .card_reset_n_o(crst_n),
        .card_perr_n_o(perr_n), .pci_serr_n_o(serr_n),
        .target_abort_o(tab), .vga_claim_o(vga), .isa_block_o(isab));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s: expected %h seen %h", n, e, s);
        end
    endtask : chk

    // request dropped after its taking edge: req is one access per cycle
    task automatic cfg(input logic we, input logic fn, input logic [5:0] dw,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(negedge clk_i);
        cfg_i <= '{1'b1, we, fn, dw, 4'b1111, wd};
        @(negedge clk_i);
        cfg_i.req <= 1'b0;
        chk("ack", {31'd0, ack}, 32'd1);
        rd = rdata;
    endtask : cfg

    task automatic wrc(input logic fn, input logic [15:0] v);
        logic [31:0] rd;
        cfg(1'b1, fn, 6'h0f, {v, 16'h0000}, rd);
    endtask : wrc

    task automatic rdr(input logic fn, input logic [5:0] dw,
                       input logic [31:0] e);
        logic [31:0] rd;
        cfg(1'b0, fn, dw, 32'h0, rd);
        chk("cfg read", rd, e);
    endtask : rdr

    // event seen one cycle late, then gone one cycle after release
    task automatic evt(input logic s, input logic [2:0] k,
                       input logic [6:0] e);
        @(negedge clk_i);
        sock <= s;
        ev   <= k;
        @(negedge clk_i);
        chk("event", {post, perr_n, serr_n, tab}, e);
        ev <= 3'd0;
        @(negedge clk_i);
        chk("event idle", {post, perr_n, serr_n, tab}, 7'b00_11_1_00);
    endtask : evt

    task automatic fwd(input logic [31:0] a, input logic io,
                       input logic [3:0] e);
        @(negedge clk_i);
        addr  <= a;
        is_io <= io;
        @(negedge clk_i);
        chk("forward", {vga, isab}, e);
    endtask : fwd

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdr(1'b0, 6'h0f, 32'h0340_0000);
        rdr(1'b1, 6'h0f, 32'h0340_0000);
        rdr(1'b0, 6'h10, 32'h0000_0000);
        chk("crst", crst_n, 2'b00);
        chk("prefetch", {sctl[1][4:3], sctl[0][4:3]}, 4'hf);
    endtask : t_reset

    task automatic t_mask;
        wrc(1'b0, 16'hffff);
        rdr(1'b0, 6'h0f, 32'h07ef_0000);
        wrc(1'b1, 16'hffff);
        rdr(1'b1, 6'h0f, 32'h07ef_0000);
        wrc(1'b1, 16'h0000);
        rdr(1'b1, 6'h0f, 32'h0023_0000);
        chk("glob", gctl, 3'b111);
        chk("sock", sctl, 12'h03f);
        chk("crst", crst_n, 2'b10);
        @(negedge clk_i);
        primary_reset_in <= 1'b1;
        @(negedge clk_i);
        chk("crst", crst_n, 2'b00);
        primary_reset_in <= 1'b0;
    endtask : t_mask

    task automatic t_ident;
        logic [31:0] rd;
        cfg(1'b1, 1'b0, 6'h10, 32'h1234_5678, rd);
        rdr(1'b0, 6'h10, 32'h0000_0000);
        id_wen <= 2'b01;
        cfg(1'b1, 1'b0, 6'h10, 32'h1234_5678, rd);
        rdr(1'b0, 6'h10, 32'h1234_5678);
        rdr(1'b1, 6'h10, 32'h0000_0000);
        id_wen <= 2'b00;
    endtask : t_ident

    task automatic t_events;
        serr_en <= 1'b1;
        evt(1'b0, 3'd1, 7'b01_11_1_00);
        evt(1'b1, 3'd1, 7'b00_11_1_00);
        evt(1'b0, 3'd2, 7'b00_11_0_00);
        evt(1'b1, 3'd2, 7'b00_11_0_00);
        evt(1'b0, 3'd3, 7'b00_10_1_00);
        evt(1'b1, 3'd3, 7'b00_01_1_00);
        evt(1'b0, 3'd4, 7'b00_11_0_01);
        serr_en <= 1'b0;
        evt(1'b1, 3'd4, 7'b00_11_1_10);
        fwd(32'h000a_0000, 1'b0, 4'b0100);
        fwd(32'h0000_03c0, 1'b1, 4'b0101);
        fwd(32'h0000_0100, 1'b1, 4'b0001);
        fwd(32'h0000_00ff, 1'b1, 4'b0000);
        wrc(1'b0, 16'h0000);
        evt(1'b0, 3'd2, 7'b00_11_1_00);
        evt(1'b0, 3'd3, 7'b00_11_1_00);
        evt(1'b0, 3'd4, 7'b00_11_1_00);
        fwd(32'h000a_0000, 1'b0, 4'b0000);
    endtask : t_events

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    initial begin
        repeat (3) @(negedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_mask();
        t_ident();
        t_events();
        final_report();
    end

    // run needs about 80 cycles; 3000 leaves ample margin
    initial begin
        #(3000 * 100);
        bad_count++;
        final_report();
    end
endmodule : cbctl_bridge_ctrl_tb

// [sim/cbctl_card_model.sv]
/*
 * Card socket model: raises one socket event on command from the bench.
 * Assumes the bench changes its command just after a falling clock edge.
 */
`timescale 1ns/1ps
module cbctl_card_model (
    input  wire logic [0:0] sock_i,     // socket the event hits
    input  wire logic [2:0] ev_i,       // 0 idle 1 burst 2 serr 3 perr 4 abt
    output logic      [1:0] burst_o,    // burst write in progress
    output logic      [1:0] syserr_n_o, // CSERR#, low
    output logic      [1:0] perr_o,     // parity error seen
    output logic      [1:0] mabort_o    // master abort seen
);
    // released CSERR# floats to its pull-up level
    always_comb begin
        burst_o    = 2'b00;
        syserr_n_o = 2'b11;
        perr_o     = 2'b00;
        mabort_o   = 2'b00;
        case (ev_i)
            3'd1: burst_o[sock_i]    = 1'b1;
            3'd2: syserr_n_o[sock_i] = 1'b0;
            3'd3: perr_o[sock_i]     = 1'b1;
            3'd4: mabort_o[sock_i]   = 1'b1;
            default: ;
        endcase
    end
endmodule : cbctl_card_model
